/* File: core/pas_port_a_set.sv */
/*
 * Port A output set block: 32 output data latches, set-only register, direction register.
 * Assumes an APB master on sys_clk and an external pad that honours the output enable.
 */
// Summary of operation
// - Set register is 32 bits; bit n acts on pin n's latch.
// - Zero bits written leave latch and pin unchanged.
// - Reads of the set register always return zero.
// - A one bit forces the matching latch high.
// - A one bit on an output pin drives that pin high.
// - A one bit on a non-output pin sets the latch but leaves pin undriven.
`timescale 1ns/10ps
module pas_port_a_set
	import pas_pkg::*;
#(
	parameter int PINS = PAS_PIN_COUNT
) (
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [PAS_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic      [PINS-1:0]       port_a_pin_bits_o,
	output logic      [PINS-1:0]       port_a_pin_bits_oe,
	output logic      [PINS-1:0]       port_a_latch
);
	if (PINS != 32) begin : g_bad_pins
		$error("pas_port_a_set supports exactly 32 pins");
	end

	logic            wr_set;
	logic            wr_dir;
	logic            rd_ok;
	logic            bad_addr;
	logic [PINS-1:0] latch_q;
	logic [PINS-1:0] latch_d;
	logic [PINS-1:0] dir_q;
	logic [PINS-1:0] dir_d;
	logic [31:0]     prdata_d;
	logic [31:0]     prdata_q;
	logic            pslverr_d;
	logic            pslverr_q;
	logic            pready_q;
	logic            pready_d;

	pas_apb_slave u_apb (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.wr_set   (wr_set),
		.wr_dir   (wr_dir),
		.rd_ok    (rd_ok),
		.bad_addr (bad_addr)
	);

	always_comb begin
		latch_d = latch_q;
		// Writes land only at the edge where pready is sampled high
		if (wr_set & pready_q) begin
			latch_d = latch_q | pwdata[PINS-1:0];
		end
		dir_d = dir_q;
		if (wr_dir & pready_q) begin
			dir_d = pwdata[PINS-1:0];
		end
	end

	// Read data is decoded off the request and registered so it is valid when pready is high
	always_comb begin
		prdata_d  = PAS_READ_ZERO;
		pslverr_d = bad_addr;
		if (rd_ok) begin
			unique case (paddr)
				PAS_OUTPUT_SET:   prdata_d = PAS_READ_ZERO;
				PAS_DIRECTION:    prdata_d = dir_q;
				PAS_LATCH_STATUS: prdata_d = latch_q;
				default:          prdata_d = PAS_READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			latch_q   <= PAS_LATCH_RESET;
			dir_q     <= PAS_DIR_RESET;
			prdata_q  <= PAS_READ_ZERO;
			pslverr_q <= 1'b0;
		end else begin
			latch_q   <= latch_d;
			dir_q     <= dir_d;
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Registered answer: pready goes high one cycle into the access phase
	always_comb begin
		pready_d = psel & penable & ~pready_q;
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= pready_d;
		end
	end

	always_comb begin
		pready  = pready_q;
		prdata  = prdata_q;
		pslverr = pslverr_q;
	end

	pas_pin_driver #(
		.WIDTH (PINS)
	) u_pins (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.latch   (latch_q),
		.dir_out (dir_q),
		.pin_o   (port_a_pin_bits_o),
		.pin_oe  (port_a_pin_bits_oe)
	);

	always_comb begin
		port_a_latch = latch_q;
	end
endmodule

/* File: core/pas_pkg.sv */
/*
 * Package for the port A output set block: register map, reset values and widths.
 * Assumes a 32-bit APB bus with one aligned word per register.
 */
package pas_pkg;
	localparam int          PAS_PIN_COUNT     = 32;
	localparam int          PAS_ADDR_W        = 12;
	// Register byte addresses
	localparam logic [11:0] PAS_OUTPUT_SET    = 12'h000;
	localparam logic [11:0] PAS_DIRECTION     = 12'h004;
	localparam logic [11:0] PAS_LATCH_STATUS  = 12'h008;
	// Values after reset
	localparam logic [31:0] PAS_LATCH_RESET   = 32'h0000_0000;
	localparam logic [31:0] PAS_DIR_RESET     = 32'h0000_0000;
	localparam logic [31:0] PAS_READ_ZERO     = 32'h0000_0000;
endpackage

/* File: core/pas_apb_slave.sv */
/*
 * APB slave front end: decodes one access per transfer; the top answers with one wait state.
 * Assumes an APB master on sys_clk; pslverr flags unmapped addresses.
 */
`timescale 1ns/10ps
module pas_apb_slave
	import pas_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [PAS_ADDR_W-1:0] paddr,
	output logic                       wr_set,
	output logic                       wr_dir,
	output logic                       rd_ok,
	output logic                       bad_addr
);
	logic access;

	// Decode is held through the access phase; the top adds one wait state
	always_comb begin
		access   = psel & penable;
		wr_set   = access & pwrite & (paddr == PAS_OUTPUT_SET);
		wr_dir   = access & pwrite & (paddr == PAS_DIRECTION);
		rd_ok    = access & ~pwrite;
		bad_addr = access & (paddr != PAS_OUTPUT_SET) & (paddr != PAS_DIRECTION)
			& (paddr != PAS_LATCH_STATUS);
	end
endmodule

/* File: core/pas_pin_driver.sv */
/*
 * Per-pin output stage: the pin is driven from its latch only while configured as output.
 * Assumes latch and direction come from the same clock domain.
 */
`timescale 1ns/10ps
module pas_pin_driver #(
	parameter int WIDTH = 32
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] latch,
	input  wire logic [WIDTH-1:0] dir_out,
	output logic      [WIDTH-1:0] pin_o,
	output logic      [WIDTH-1:0] pin_oe
);
	logic [WIDTH-1:0] pin_d;
	logic [WIDTH-1:0] oe_d;

	for (genvar i = 0; i < WIDTH; i++) begin : g_pin
		always_comb begin
			pin_d[i] = latch[i] & dir_out[i];
			oe_d[i]  = dir_out[i];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pin_o  <= '0;
			pin_oe <= '0;
		end else begin
			pin_o  <= pin_d;
			pin_oe <= oe_d;
		end
	end
endmodule

/* File: verification/pas_port_a_set_sva.sv */
/* Checker for the port A set block.
 * Sees only top ports; bound from the bench. */
`timescale 1ns/10ps
module pas_port_a_set_sva
	import pas_pkg::*;
#(
	parameter int PINS = 32
) (
	input wire logic                  sys_clk,
	input wire logic                  sys_rst,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [PAS_ADDR_W-1:0] paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [PINS-1:0]       port_a_pin_bits_o,
	input wire logic [PINS-1:0]       port_a_pin_bits_oe,
	input wire logic [PINS-1:0]       port_a_latch
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire wr = psel && penable && pready && pwrite && paddr == PAS_OUTPUT_SET;
	a_one_set: assert property (
		wr |=> (port_a_latch & $past(pwdata)) == $past(pwdata)) else $error("bit not set");
	a_zero_keep: assert property (
		wr |=> (port_a_latch | $past(pwdata)) == ($past(port_a_latch) | $past(pwdata)))
		else $error("zero bit changed");
	a_read_zero: assert property (
		pready && !pwrite && paddr == PAS_OUTPUT_SET |-> prdata == '0) else $error("read not 0");
	a_pin_drive: assert property (
		port_a_pin_bits_o == ($past(port_a_latch) & port_a_pin_bits_oe)) else $error("pin level");
	a_pin_undriven: assert property (
		(port_a_pin_bits_o & ~port_a_pin_bits_oe) == '0) else $error("undriven pin high");
	a_latch_hold: assert property (
		!wr |=> $stable(port_a_latch)) else $error("latch moved");
	a_read_wait: assert property (
		psel && penable && !pready |=> pready) else $error("no answer");
	cover property (wr);
	cover property (pready && !pwrite);
	cover property (pslverr);
endmodule

/* File: verification/pas_port_a_set_bench.sv */
/* Bench for the port A set block: APB master, model, checks.
 * Waits for pready for at most 9 clock edges, then ends the run as failed. */
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module pas_port_a_set_bench;
	import pas_pkg::*;
	logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, lat = 0, dir = 0;
	logic [31:0] port_a_pin_bits_o, port_a_pin_bits_oe, port_a_latch;
	int fail_count = 0, compares = 0;
	always #5 sys_clk = ~sys_clk;
	pas_port_a_set u_pas_port_a_set (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .port_a_pin_bits_o, .port_a_pin_bits_oe,
		.port_a_latch);
	task print_verdict;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge sys_clk) penable <= 1;
		n = 0;
		do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 9);
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
		// One idle edge so a following call never re-drives psel in this step
		@(posedge sys_clk);
		if (n >= 9) begin fail_count++; print_verdict; end
	endtask
	task set_chk(input logic [31:0] d);
		apb(1, PAS_OUTPUT_SET, d);
		lat = lat | d;
		repeat (3) @(posedge sys_clk);
		`CHK(port_a_latch, lat)
		`CHK(port_a_pin_bits_o, lat & dir)
		`CHK(port_a_pin_bits_oe, dir)
	endtask
	initial begin
		void'($urandom(7));
		repeat (10) @(posedge sys_clk);
		sys_rst <= 0;
		@(posedge sys_clk);
		for (int i = 0; i < 32; i++) set_chk(32'h1 << i);
		$display("bits test done");
		sys_rst <= 1;
		@(posedge sys_clk) sys_rst <= 0;
		lat = 0;
		set_chk(32'h0);
		for (int i = 0; i < 8; i++) begin
			dir = $urandom;
			apb(1, PAS_DIRECTION, dir);
			set_chk($urandom & $urandom);
		end
		$display("direction test done");
		apb(0, PAS_OUTPUT_SET, 0);
		`CHK(rd, PAS_READ_ZERO)
		apb(0, PAS_DIRECTION, 0);
		`CHK(rd, dir)
		apb(0, PAS_LATCH_STATUS, 0);
		`CHK(rd, lat)
		apb(1, 12'hffc, 32'hffff_ffff);
		`CHK(err, 1'b1)
		set_chk(32'h0);
		$display("read test done");
		print_verdict;
	end
endmodule
bind pas_port_a_set pas_port_a_set_sva #(.PINS(PINS)) u_sva (.sys_clk, .sys_rst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port_a_pin_bits_o,
	.port_a_pin_bits_oe, .port_a_latch);
